// ### irqp_regs.sv
// Interrupt priority level register slice with AXI4-Lite access and arbitration
`timescale 1ns/1ns
`default_nettype none

module irqp_regs
  import irqp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral requests, same clock, in vector order
  input wire logic [IRQP_NUM_SRC-1:0] irq_req,
  input wire logic watchdog_req,
  // Toward the core
  output logic irq_valid,
  output logic [1:0] irq_level,
  output logic [IRQP_SRC_W-1:0] irq_src
);

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] irqp_decode(input logic [31:0] addr);
    logic [2:0] sel;
    sel = IRQP_SEL_MISS;
    if (addr[31:6] == '0 && addr[1:0] == 2'h0) begin
      case (addr[5:2])
        IRQP_IDX_TIMER_D_DECODER: sel = 3'h0;
        IRQP_IDX_TIMERS_AB_C: sel = 3'h1;
        IRQP_IDX_SERIAL0_TIMER_A: sel = 3'h2;
        IRQP_IDX_PWM_ADC: sel = 3'h3;
        IRQP_IDX_WINNER_STATUS: sel = IRQP_SEL_WINNER;
        IRQP_IDX_PENDING_STATUS: sel = IRQP_SEL_PENDING;
        default: sel = IRQP_SEL_MISS;
      endcase
    end
    return sel;
  endfunction : irqp_decode

  // Field code to level; code 00 has no level and must be gated by irqp_enabled
  function automatic logic [1:0] irqp_level(input logic [1:0] field);
    return field - 2'h1;
  endfunction : irqp_level

  function automatic logic irqp_enabled(input logic [1:0] field);
    return field != IRQP_FIELD_OFF;
  endfunction : irqp_enabled

  // ==========================================================================
  // Write channel
  logic [15:0] prio [IRQP_NUM_REGS];
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  // Address and data are taken in either order; commit once both sit here
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [2:0] wr_sel = irqp_decode(aw_addr);
  wire wr_hit = ~wr_sel[2];
  wire [15:0] wr_bytes = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire next_aw_held = (aw_held | aw_hs) & ~do_write;
  wire next_w_held = (w_held | w_hs) & ~do_write;
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IRQP_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= (wr_hit || wr_sel == IRQP_SEL_WINNER || wr_sel == IRQP_SEL_PENDING) ?
                       IRQP_RESP_OKAY : IRQP_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
      end
    end
  end

  // ==========================================================================
  // Priority registers
  for (genvar r = 0; r < IRQP_NUM_REGS; r++) begin : g_reg
    wire [15:0] keep = IRQP_MASK[r] & wr_bytes;
    wire sel_me = do_write && wr_sel == 3'(r);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        prio[r] <= IRQP_RESET_VALUE;
      end else if (sel_me) begin
        prio[r] <= (prio[r] & ~keep) | (w_data & keep);
      end
    end
  end

  // ==========================================================================
  // Field extraction and gating
  logic [1:0] field [IRQP_NUM_SRC];
  logic [1:0] lvl [IRQP_NUM_SRC];
  logic [IRQP_NUM_SRC-1:0] pend;
  logic [IRQP_NUM_SRC-1:0] req_all;

  for (genvar s = 0; s < IRQP_NUM_SRC; s++) begin : g_src
    assign field[s] = prio[IRQP_FIELD_REG[s]][IRQP_FIELD_LSB[s] +: 2];
    if (s == IRQP_SRC_DEC0_HOME) begin : g_shared
      assign req_all[s] = irq_req[s] | watchdog_req;
    end else begin : g_plain
      assign req_all[s] = irq_req[s];
    end
    assign lvl[s] = irqp_level(field[s]);
    assign pend[s] = req_all[s] & irqp_enabled(field[s]);
  end

  // ==========================================================================
  // Arbitration
  logic best_ok;
  logic [1:0] best_lvl;
  logic [IRQP_SRC_W-1:0] best_src;

  // Scan downward with >= so the lower vector keeps a tie
  always_comb begin
    best_ok = 1'b0;
    best_lvl = 2'h0;
    best_src = '0;
    for (int i = IRQP_NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!best_ok || lvl[i] >= best_lvl)) begin
        best_ok = 1'b1;
        best_lvl = lvl[i];
        best_src = IRQP_SRC_W'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_valid <= 1'b0;
      irq_level <= 2'h0;
      irq_src <= '0;
    end else begin
      irq_valid <= best_ok;
      irq_level <= best_lvl;
      irq_src <= best_src;
    end
  end

  // ==========================================================================
  // Read channel
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire [2:0] rd_sel = irqp_decode(s_axi_araddr);
  wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] rd_winner = {24'h0, irq_valid, irq_level, irq_src};
  wire [31:0] rd_pending = {{(32 - IRQP_NUM_SRC){1'b0}}, pend};
  wire [31:0] rd_word = (rd_sel == IRQP_SEL_WINNER) ? rd_winner :
                        (rd_sel == IRQP_SEL_PENDING) ? rd_pending :
                        (~rd_sel[2]) ? {16'h0, prio[rd_sel[1:0]]} : 32'h0;
  wire [1:0] rd_resp = (rd_sel == IRQP_SEL_MISS) ? IRQP_RESP_SLVERR : IRQP_RESP_OKAY;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= IRQP_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [1:0] field_q [IRQP_NUM_SRC];
  logic [IRQP_NUM_SRC-1:0] pend_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
      for (int i = 0; i < IRQP_NUM_SRC; i++) begin
        field_q[i] <= IRQP_FIELD_OFF;
      end
    end else begin
      pend_q <= pend;
      for (int i = 0; i < IRQP_NUM_SRC; i++) begin
        field_q[i] <= field[i];
      end
    end
  end

  function automatic logic irqp_outranked(input logic [IRQP_SRC_W-1:0] src,
                                          input logic [1:0] level);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < IRQP_NUM_SRC; j++) begin
      if (pend_q[j] && (irqp_level(field_q[j]) > level ||
          (irqp_level(field_q[j]) == level && j < int'(src)))) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : irqp_outranked

  // Function reads module state, so evaluate it in logic and let the assertion sample the result
  logic winner_outranked;
  always_comb begin
    winner_outranked = irqp_outranked(irq_src, irq_level);
  end

  sequence s_write_done(logic [2:0] slot);
    $rose(s_axi_bvalid) && wr_sel == slot && w_strb == 2'h3;
  endsequence

  a_level_decode: assert property (@(posedge clk) disable iff (!arst_n)
    irq_valid |-> field_q[irq_src] == irq_level + 2'h1)
    else $error("winner level does not match its field code");
  a_level_cap: assert property (@(posedge clk) disable iff (!arst_n)
    irq_valid |-> irq_level <= IRQP_LEVEL_MAX)
    else $error("level above two granted");
  a_reset_clear: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> prio[0] == '0 && prio[1] == '0 && prio[2] == '0 && prio[3] == '0)
    else $error("priority fields not clear after reset");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (prio[0] & ~IRQP_MASK[0]) == '0 && (prio[2] & ~IRQP_MASK[2]) == '0)
    else $error("reserved bits hold a value");
  a_reg6_place: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_done(3'h0) |-> field[IRQP_SRC_TIMER_D_CH1] == w_data[9:8] &&
                           field[IRQP_SRC_DEC0_INDEX] == w_data[3:2])
    else $error("register six fields misplaced");
  a_shared_home: assert property (@(posedge clk) disable iff (!arst_n)
    watchdog_req && irqp_enabled(field[IRQP_SRC_DEC0_HOME]) |=> irq_valid)
    else $error("watchdog request not forwarded on the shared slot");
  a_reg7_place: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_done(3'h1) |-> field[IRQP_SRC_TIMER_A_CH0] == w_data[15:14] &&
                           field[IRQP_SRC_TIMER_C_CH1] == w_data[1:0])
    else $error("register seven fields misplaced");
  a_reg8_place: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_done(3'h2) |-> field[IRQP_SRC_SERIAL0_RX_FULL] == w_data[15:14] &&
                           field[IRQP_SRC_SERIAL0_TX_IDLE] == w_data[9:8])
    else $error("register eight fields misplaced");
  a_reg9_pwm: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_done(3'h3) |-> field[IRQP_SRC_PWM_A_FAULT] == w_data[15:14] &&
                           field[IRQP_SRC_PWM_B_RELOAD] == w_data[9:8])
    else $error("register nine PWM fields misplaced");
  a_reg9_adc: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_done(3'h3) |-> field[IRQP_SRC_ADC_A_ZERO_LIMIT] == w_data[7:6] &&
                           field[IRQP_SRC_ADC_A_CONV_DONE] == w_data[3:2])
    else $error("register nine ADC fields misplaced");
  a_disabled_gate: assert property (@(posedge clk) disable iff (!arst_n)
    irq_valid |-> pend_q[irq_src] && irqp_enabled(field_q[irq_src]))
    else $error("disabled or idle source forwarded");
  a_arbiter_pick: assert property (@(posedge clk) disable iff (!arst_n)
    irq_valid |-> !winner_outranked)
    else $error("winner outranked by another pending source");
  a_idle_none: assert property (@(posedge clk) disable iff (!arst_n)
    pend == '0 |=> !irq_valid)
    else $error("request forwarded with nothing pending");
  a_idle_level: assert property (@(posedge clk) disable iff (!arst_n)
    !irq_valid |-> irq_level == 2'h0)
    else $error("level shown with no winner");
  a_shared_req: assert property (@(posedge clk) disable iff (!arst_n)
    irq_req[IRQP_SRC_DEC0_HOME] && irqp_enabled(field[IRQP_SRC_DEC0_HOME]) |=> irq_valid)
    else $error("home request not forwarded on the shared slot");

  // ==========================================================================
  // Bus handshake checks
  // Both halves parked and no response owed means the commit happens now
  sequence s_write_ready;
    aw_held && w_held && !s_axi_bvalid;
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_write_ready |=> s_axi_bvalid)
    else $error("write not answered one edge after both halves arrived");
  a_bresp_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_write_block: assert property (@(posedge clk) disable iff (!arst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while a response is owed");
  a_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_taken |=> s_axi_rvalid)
    else $error("read not answered one edge after it was taken");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_read_block: assert property (@(posedge clk) disable iff (!arst_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while data is owed");
  a_miss_error: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_taken ##0 rd_sel == IRQP_SEL_MISS |=>
      s_axi_rresp == IRQP_RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  // ==========================================================================
  // Per-source checks, driven by the field table
  // Covers every field, not only the sampled few above
  for (genvar s = 0; s < IRQP_NUM_SRC; s++) begin : g_src_chk
    a_field_place: assert property (@(posedge clk) disable iff (!arst_n)
      s_write_done(3'(IRQP_FIELD_REG[s])) |-> field[s] == w_data[IRQP_FIELD_LSB[s] +: 2])
      else $error("field landed outside its bit pair");
    a_off_silent: assert property (@(posedge clk) disable iff (!arst_n)
      !irqp_enabled(field[s]) |=> !(irq_valid && irq_src == IRQP_SRC_W'(s)))
      else $error("source with a zero field was forwarded");
  end

endmodule : irqp_regs

`default_nettype wire

// ### irqp_pkg.sv
// Constants and field map for the interrupt priority level register slice
// Overview of operation
// - Field code 00 disables the request; 01, 10, 11 give levels 0, 1, 2.
// - No field code may grant these sources any level above two.
// - Reset clears every priority field, so all covered sources start disabled.
// - Reserved bits 5-4 of register six and 11-10 of eight read zero, ignore writes.
// - Register six: timer D ch1 at 9-8, ch0 at 7-6, decoder 0 index at 3-2.
// - Decoder 0 home and watchdog share one request, priority from register six bits 1-0.
// - Register seven: timer A ch0 at 15-14, timer B ch3..0, timer C ch3..1 to 1-0.
// - Register eight: serial 0 rx full, rx error, tx idle, tx empty; timer A ch3..1.
// - Register nine: PWM A/B fault at 15-12, PWM A/B reload at 11-8.
// - Register nine: ADC A/B zero-limit at 7-4, ADC A/B conversion done at 3-0.
package irqp_pkg;

  // ==========================================================================
  // Register map (index; byte address is four times the index)
  localparam logic [3:0] IRQP_IDX_TIMER_D_DECODER = 4'h6;
  localparam logic [3:0] IRQP_IDX_TIMERS_AB_C = 4'h7;
  localparam logic [3:0] IRQP_IDX_SERIAL0_TIMER_A = 4'h8;
  localparam logic [3:0] IRQP_IDX_PWM_ADC = 4'h9;
  localparam logic [3:0] IRQP_IDX_WINNER_STATUS = 4'ha;
  localparam logic [3:0] IRQP_IDX_PENDING_STATUS = 4'hb;

  localparam int IRQP_NUM_REGS = 4;
  localparam logic [15:0] IRQP_RESET_VALUE = 16'h0000;
  // Bits 15-10 of register six belong to fields outside this slice
  localparam logic [15:0] IRQP_MASK [IRQP_NUM_REGS] = '{16'h03cf, 16'hffff, 16'hf3ff, 16'hffff};

  // Decoder result codes: 0..3 priority slots, then status, then miss
  localparam logic [2:0] IRQP_SEL_WINNER = 3'h4;
  localparam logic [2:0] IRQP_SEL_PENDING = 3'h5;
  localparam logic [2:0] IRQP_SEL_MISS = 3'h7;

  localparam logic [1:0] IRQP_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRQP_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Priority field encoding
  localparam logic [1:0] IRQP_FIELD_OFF = 2'h0;
  localparam logic [1:0] IRQP_LEVEL_MAX = 2'h2;

  // ==========================================================================
  // Field table, in fixed vector order (lower index wins ties)
  localparam int IRQP_NUM_SRC = 27;
  localparam int IRQP_SRC_W = 5;
  localparam int IRQP_SRC_DEC0_HOME = 3;
  localparam int IRQP_FIELD_REG [IRQP_NUM_SRC] = '{
    0, 0, 0, 0,
    1, 1, 1, 1, 1, 1, 1, 1,
    2, 2, 2, 2, 2, 2, 2,
    3, 3, 3, 3, 3, 3, 3, 3};
  localparam int IRQP_FIELD_LSB [IRQP_NUM_SRC] = '{
    8, 6, 2, 0,
    14, 12, 10, 8, 6, 4, 2, 0,
    14, 12, 8, 6, 4, 2, 0,
    14, 12, 10, 8, 6, 4, 2, 0};

  // Source indices used by checks
  localparam int IRQP_SRC_TIMER_D_CH1 = 0;
  localparam int IRQP_SRC_DEC0_INDEX = 2;
  localparam int IRQP_SRC_TIMER_A_CH0 = 4;
  localparam int IRQP_SRC_TIMER_C_CH1 = 11;
  localparam int IRQP_SRC_SERIAL0_RX_FULL = 12;
  localparam int IRQP_SRC_SERIAL0_TX_IDLE = 14;
  localparam int IRQP_SRC_PWM_A_FAULT = 19;
  localparam int IRQP_SRC_PWM_B_RELOAD = 22;
  localparam int IRQP_SRC_ADC_A_ZERO_LIMIT = 23;
  localparam int IRQP_SRC_ADC_A_CONV_DONE = 25;

endpackage : irqp_pkg

// ### irqp_core_model.sv
// Behavioural core side that takes the prioritized request
`timescale 1ns/1ns
`default_nettype none

module irqp_core_model
  import irqp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irq_valid,
  input wire logic [1:0] irq_level,
  input wire logic [IRQP_SRC_W-1:0] irq_src,
  output logic [IRQP_SRC_W-1:0] taken_src,
  output logic level_bad
);
  // ==========================================================================
  // Winner capture
  // Sticky flag, so a single bad cycle is still seen at the end of the run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      taken_src <= '0;
      level_bad <= 1'b0;
    end else if (irq_valid) begin
      taken_src <= irq_src;
      if (irq_level > IRQP_LEVEL_MAX) level_bad <= 1'b1;
    end
  end
endmodule : irqp_core_model

`default_nettype wire

// ### irqp_regs_tb.sv
// Self-checking bench for the interrupt priority register slice
`timescale 1ns/1ns
`default_nettype none

module irqp_regs_tb import irqp_pkg::*;;
  typedef struct packed {
    logic [31:0] a;
    logic [15:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic [1:0] r;
  } irqp_row_t;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [IRQP_NUM_SRC-1:0] irq_req = '0;
  logic wd_req = 1'b0;
  logic irq_valid;
  logic [1:0] irq_level;
  logic [IRQP_SRC_W-1:0] irq_src, taken_src;
  logic level_bad;
  int n_fail = 0;
  int samples_checked = 0;
  // Byte-lane row shows wstrb keeps the untouched half
  irqp_row_t rows [7] = '{
    '{32'h18, 16'hffff, 4'h3, 16'h03cf, IRQP_RESP_OKAY},
    '{32'h1c, 16'hffff, 4'h3, 16'hffff, IRQP_RESP_OKAY},
    '{32'h20, 16'hffff, 4'h3, 16'hf3ff, IRQP_RESP_OKAY},
    '{32'h24, 16'hffff, 4'h3, 16'hffff, IRQP_RESP_OKAY},
    '{32'h24, 16'h0000, 4'h1, 16'hff00, IRQP_RESP_OKAY},
    '{32'h30, 16'hffff, 4'h3, 16'h0000, IRQP_RESP_SLVERR},
    '{32'h28, 16'hffff, 4'h3, 16'h0000, IRQP_RESP_OKAY}};

  always #4 clk = ~clk;

  irqp_regs DUT (.clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req), .watchdog_req(wd_req),
    .irq_valid(irq_valid), .irq_level(irq_level), .irq_src(irq_src));

  irqp_core_model core (.clk(clk), .arst_n(arst_n), .irq_valid(irq_valid),
    .irq_level(irq_level), .irq_src(irq_src), .taken_src(taken_src), .level_bad(level_bad));

  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Address and data are offered together; each is dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic setf(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'h3, r);
    chk("bresp", {30'h0, IRQP_RESP_OKAY}, {30'h0, r});
  endtask : setf

  // Outputs follow one edge after a change; three edges leave margin
  task automatic chk_irq(input logic v, input logic [1:0] l, input logic [4:0] s);
    repeat (3) @(posedge clk);
    chk("irq_valid", {31'h0, v}, {31'h0, irq_valid});
    chk("irq_level", {30'h0, l}, {30'h0, irq_level});
    if (v) chk("irq_src", {27'h0, s}, {27'h0, irq_src});
    if (v) chk("core_src", {27'h0, s}, {27'h0, taken_src});
  endtask : chk_irq

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    logic [31:0] a;
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 7; i++) begin
      axi_wr(rows[i].a, {16'h0, rows[i].d}, rows[i].s, r);
      chk("bresp", {30'h0, rows[i].r}, {30'h0, r});
      axi_rd(rows[i].a, d, r);
      chk("rdata", {16'h0, rows[i].e}, d);
      chk("rresp", {30'h0, rows[i].r}, {30'h0, r});
    end
    $display("test register rows done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      axi_rd(32'(32'h18 + 4 * i), d, r);
      chk("reset_value", {16'h0, IRQP_RESET_VALUE}, d);
    end
    irq_req <= '1;
    chk_irq(1'b0, 2'h0, 5'h0);
    $display("test mid-run reset done");
    for (i = 0; i < 4; i++) begin
      setf(32'h1c, 32'(i) << 14);
      chk_irq(i != 0, (i == 0) ? 2'h0 : 2'(i - 1), 5'h4);
    end
    setf(32'h1c, 32'h0);
    $display("test field codes done");
    for (i = 0; i < IRQP_NUM_SRC; i++) begin
      a = 32'(32'h18 + 4 * IRQP_FIELD_REG[i]);
      setf(a, 32'h3 << IRQP_FIELD_LSB[i]);
      chk_irq(1'b1, 2'h2, 5'(i));
      setf(a, 32'h0);
    end
    $display("test field map done");
    setf(32'h1c, 32'h7000);
    chk_irq(1'b1, 2'h2, 5'h5);
    setf(32'h1c, 32'ha000);
    chk_irq(1'b1, 2'h1, 5'h4);
    $display("test arbitration done");
    setf(32'h1c, 32'h0);
    irq_req <= '0;
    setf(32'h18, 32'h2);
    wd_req <= 1'b1;
    chk_irq(1'b1, 2'h1, 5'h3);
    axi_rd(32'h28, d, r);
    chk("winner_status", 32'ha3, d);
    axi_rd(32'h2c, d, r);
    chk("pending_status", 32'h8, d);
    wd_req <= 1'b0;
    chk_irq(1'b0, 2'h0, 5'h0);
    chk("core_level_bad", 32'h0, {31'h0, level_bad});
    $display("test shared watchdog done");
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule : irqp_regs_tb

`default_nettype wire
